// *** verilog/dit_pkg.sv ***
// Purpose: Shared constants and types for the debug injection block
// Assumes: Mode control literals are written {first pin, second pin}
// Notes: Status codes are the values shown on the state outputs
// ==========================================================
// Package
package dit_pkg;
    // Mode control codes
    localparam logic [1:0] MODE_INJECT = 2'b00;
    localparam logic [1:0] MODE_STEP = 2'b01;
    localparam logic [1:0] MODE_HALT = 2'b10;
    localparam logic [1:0] MODE_NORMAL = 2'b11;
    // State output codes
    localparam logic [2:0] STAT_IDLE = 3'b000;
    localparam logic [2:0] STAT_INJECT = 3'b010;
    localparam logic [2:0] STAT_RUN = 3'b100;
    // Reset values and sizes
    localparam logic [1:0] SYNC_RESET = 2'b11;
    localparam int SYNC_STAGES = 2;
    localparam int INSTR_W = 32;
    localparam logic [31:0] INSTR_RESET = 32'h0000_0000;
    // Controller states
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_HALT = 3'b001,
        ST_STEP_WAIT = 3'b010,
        ST_STEPPING = 3'b011,
        ST_STEP_DONE = 3'b100,
        ST_INJECT = 3'b101
    } dit_state_e;
endpackage : dit_pkg

// *** verilog/dit_mode_if.sv ***
// Purpose: Carries the synchronised mode code between sync and controller
// Assumes: Single clock domain
// Notes: Source is the synchroniser, sink the controller
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Interface
interface dit_mode_if;
    logic [1:0] mode;
    modport src (output mode);
    modport dst (input mode);
endinterface : dit_mode_if
`default_nettype wire

// *** verilog/dit_mode_sync.sv ***
// Purpose: Two-stage synchroniser for the asynchronous mode inputs
// Assumes: Only one mode pin changes per cycle, so bits never tear
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Synchroniser
module dit_mode_sync (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] mode_ctrl_i,
    dit_mode_if.src sync_o
);
    import dit_pkg::*;
    logic [1:0] meta;
    logic [1:0] stable;
    // Reset to normal so a quiet bench never enters debug by accident
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta <= SYNC_RESET;
            stable <= SYNC_RESET;
        end else begin
            meta <= mode_ctrl_i;
            stable <= meta;
        end
    end
    assign sync_o.mode = stable;
endmodule : dit_mode_sync
`default_nettype wire

// *** verilog/dit_inject_ctrl.sv ***
// Purpose: Instruction injection and output float control for debug
// Assumes: Pipeline, fetch unit and data channel live outside this block
// Notes: Pin floating is purely combinational from the test input
//
// What this block does
// - In injection mode the decode register loads the instruction bus, not fetch.
// - Code 00 enters injection two to three cycles later, preempting bursts.
// - Injection is entered only from halt or step wait.
// - State outputs show 010 throughout injection.
// - Bus changes reach the decode register next cycle; ready and error ignored.
// - Injection ends two to three cycles after a change to 10 or 01.
// - Leaving injection keeps the instruction; step marks it valid.
// - Halt after injection discards the instruction and restores normal fetch.
// - Every step re-executes the held instruction; host may load a no-op.
// - Injected code must not update program counters, channel or ALU status.
// - Injected code may reach protected state even in user mode.
// - A step completes only after its external data access is done.
// - Resume state is kept; halt to 11 resumes like an interrupt return.
// - Float test input floats every output except the compare error.
// - Floating is combinational, in any mode, without a clock.
// - The clock pin floats too; system must then supply the clock.
// - A 01 to 11 change advances one pipeline stage, then waits again.
// - State outputs show 000 in halt and in step wait.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Controller
module dit_inject_ctrl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] mode_ctrl_i,
    input wire logic float_test_n_i,
    input wire logic [dit_pkg::INSTR_W-1:0] instr_bus_i,
    input wire logic instruction_ready_n_i,
    input wire logic instruction_error_n_i,
    input wire logic [dit_pkg::INSTR_W-1:0] fetch_instr_i,
    input wire logic fetch_valid_i,
    input wire logic pipe_hold_i,
    input wire logic data_busy_i,
    output logic [dit_pkg::INSTR_W-1:0] decode_holding_register_o,
    output logic dhr_valid_o,
    output logic stage_advance_o,
    output logic burst_preempt_o,
    output logic refetch_o,
    output logic resume_return_o,
    output logic spr_update_inhibit_o,
    output logic priv_override_o,
    output logic [2:0] cpu_state_o,
    output logic cpu_state_oe_o,
    output logic outputs_oe_o,
    output logic system_clock_pin_oe_o,
    output logic master_slave_compare_error_o,
    input wire logic compare_error_i
);
    import dit_pkg::*;

    // ==========================================================
    // Synchronised mode
    dit_mode_if mode_bus ();
    logic [1:0] mode;
    logic [1:0] mode_q;
    dit_state_e state;
    dit_state_e next_state;
    logic inj_held;
    logic advanced;
    logic [2:0] stat;

    // Asynchronous pins pass two flops before anyone decodes them
    dit_mode_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .mode_ctrl_i(mode_ctrl_i),
        .sync_o(mode_bus)
    );
    assign mode = mode_bus.mode;

    // Previous synchronised code, for transition detection
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_q <= SYNC_RESET;
        end else begin
            mode_q <= mode;
        end
    end

    // ==========================================================
    // Mode state machine
    always_comb begin
        next_state = state;
        case (state)
            ST_NORMAL: begin
                // Halt and step wait for any data access to finish
                if (!data_busy_i && mode == MODE_HALT) begin
                    next_state = ST_HALT;
                end else if (!data_busy_i && mode == MODE_STEP) begin
                    next_state = ST_STEP_WAIT;
                end
            end
            ST_HALT: begin
                if (mode == MODE_INJECT) begin
                    next_state = ST_INJECT;
                end else if (mode == MODE_NORMAL) begin
                    next_state = ST_NORMAL;
                end else if (mode == MODE_STEP) begin
                    next_state = ST_STEP_WAIT;
                end
            end
            ST_STEP_WAIT: begin
                if (mode == MODE_INJECT) begin
                    next_state = ST_INJECT;
                end else if (mode == MODE_NORMAL && mode_q == MODE_STEP) begin
                    next_state = ST_STEPPING;
                end else if (mode == MODE_HALT) begin
                    next_state = ST_HALT;
                end
            end
            ST_STEPPING: begin
                // Finish only once advanced and the data channel is idle
                if (advanced && !data_busy_i) begin
                    next_state = ST_STEP_DONE;
                end
            end
            ST_STEP_DONE: begin
                // Code 11 may linger; wait for the host to move on
                if (mode == MODE_STEP) begin
                    next_state = ST_STEP_WAIT;
                end else if (mode == MODE_HALT) begin
                    next_state = ST_HALT;
                end
            end
            ST_INJECT: begin
                if (mode == MODE_STEP) begin
                    next_state = ST_STEP_WAIT;
                end else if (mode == MODE_HALT) begin
                    next_state = ST_HALT;
                end
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Single step advance
    // Pipeline hold stretches the step; exactly one advance is issued
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            advanced <= 1'b0;
            stage_advance_o <= 1'b0;
        end else begin
            stage_advance_o <= 1'b0;
            if (state != ST_STEPPING) begin
                advanced <= 1'b0;
            end else if (!advanced && !pipe_hold_i) begin
                advanced <= 1'b1;
                stage_advance_o <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Decode holding register
    // Ready and error are deliberately not looked at while injecting
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            decode_holding_register_o <= INSTR_RESET;
            dhr_valid_o <= 1'b0;
        end else if (state == ST_INJECT) begin
            decode_holding_register_o <= instr_bus_i;
            if (next_state == ST_STEP_WAIT) begin
                dhr_valid_o <= 1'b1;
            end else begin
                dhr_valid_o <= 1'b0;
            end
        end else if (inj_held) begin
            dhr_valid_o <= 1'b1;
        end else if (fetch_valid_i && (state == ST_NORMAL || state == ST_STEPPING)) begin
            decode_holding_register_o <= fetch_instr_i;
            dhr_valid_o <= 1'b1;
        end
    end

    // Held-injection flag; cleared by halt, which restores fetch
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            inj_held <= 1'b0;
        end else if (state == ST_INJECT && next_state == ST_STEP_WAIT) begin
            inj_held <= 1'b1;
        end else if (next_state == ST_HALT || next_state == ST_INJECT) begin
            inj_held <= 1'b0;
        end
    end

    // Injected code is flagged so the core skips implicit state updates
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            spr_update_inhibit_o <= 1'b0;
            priv_override_o <= 1'b0;
        end else begin
            spr_update_inhibit_o <= inj_held;
            priv_override_o <= inj_held;
        end
    end

    // ==========================================================
    // One-cycle event pulses
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            burst_preempt_o <= 1'b0;
            refetch_o <= 1'b0;
            resume_return_o <= 1'b0;
        end else begin
            burst_preempt_o <= (state != ST_INJECT) && (next_state == ST_INJECT);
            refetch_o <= (state == ST_INJECT) && (next_state == ST_HALT);
            resume_return_o <= (state == ST_HALT) && (next_state == ST_NORMAL);
        end
    end

    // ==========================================================
    // State outputs
    always_comb begin
        case (state)
            ST_INJECT: stat = STAT_INJECT;
            ST_HALT, ST_STEP_WAIT, ST_STEP_DONE: stat = STAT_IDLE;
            default: stat = STAT_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_state_o <= STAT_RUN;
        end else begin
            cpu_state_o <= stat;
        end
    end

    // Compare error is never floated; it stays driven in test
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            master_slave_compare_error_o <= 1'b0;
        end else begin
            master_slave_compare_error_o <= compare_error_i;
        end
    end

    // ==========================================================
    // Float test
    // No flop in this path, so it works with the clock stopped
    assign cpu_state_oe_o = float_test_n_i;
    assign outputs_oe_o = float_test_n_i;
    assign system_clock_pin_oe_o = float_test_n_i;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_inject_status: assert property (
        state == ST_INJECT |=> cpu_state_o == STAT_INJECT)
        else $error("status not 010 in injection");
    chk_idle_status: assert property (
        (state == ST_HALT || state == ST_STEP_WAIT) |=> cpu_state_o == STAT_IDLE)
        else $error("status not 000 in halt or step");
    chk_inject_entry: assert property (
        (state == ST_HALT || state == ST_STEP_WAIT) && $changed(mode_ctrl_i)
        && mode_ctrl_i == MODE_INJECT ##1 mode_ctrl_i == MODE_INJECT
        ##1 mode_ctrl_i == MODE_INJECT |=> state == ST_INJECT)
        else $error("injection not entered in time");
    chk_inject_origin: assert property (
        $rose(state == ST_INJECT) |-> $past(state) == ST_HALT
        || $past(state) == ST_STEP_WAIT)
        else $error("injection entered from wrong state");
    chk_bus_capture: assert property (
        state == ST_INJECT |=> decode_holding_register_o == $past(instr_bus_i))
        else $error("bus not captured");
    chk_step_valid: assert property (
        state == ST_INJECT && next_state == ST_STEP_WAIT
        |=> dhr_valid_o && inj_held ##1 dhr_valid_o)
        else $error("held instruction not valid");
    chk_halt_discard: assert property (
        state == ST_INJECT && next_state == ST_HALT |=> !dhr_valid_o && refetch_o)
        else $error("injection not discarded");
    chk_one_advance: assert property (
        stage_advance_o |-> !$past(advanced) && $past(state) == ST_STEPPING
        ##1 !stage_advance_o)
        else $error("more than one advance per step");
    chk_step_data: assert property (
        state == ST_STEPPING && data_busy_i |=> state == ST_STEPPING)
        else $error("step ended with data busy");
    chk_resume: assert property (
        state == ST_HALT && mode == MODE_NORMAL |=> resume_return_o)
        else $error("no resume pulse");
    chk_float_pins: assert property (
        !float_test_n_i |-> !outputs_oe_o && !cpu_state_oe_o && !system_clock_pin_oe_o)
        else $error("pins driven in float test");
    chk_inhibit_flags: assert property (
        inj_held |=> spr_update_inhibit_o && priv_override_o)
        else $error("injected code not flagged");

    cov_inject_step: cover property (
        state == ST_INJECT ##1 state == ST_STEP_WAIT);
    cov_step_done: cover property (
        state == ST_STEPPING ##[1:20] state == ST_STEP_DONE);
    cov_resume: cover property (resume_return_o);
endmodule : dit_inject_ctrl
`default_nettype wire

// *** tb/dit_host_model.sv ***
// Purpose: Development-system model driving mode pins and instruction bus
// Assumes: Tasks are called just after a rising edge of clk_i
// Notes: A released bus toggles every cycle so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host model
module dit_host_model (
    input wire logic clk_i,
    input wire logic [2:0] cpu_state_i,
    output logic [1:0] mode_ctrl_o,
    output logic [dit_pkg::INSTR_W-1:0] instr_bus_o
);
    import dit_pkg::*;
    // Idle pins before the first request
    initial begin
        mode_ctrl_o = MODE_NORMAL;
        instr_bus_o = 32'h0000_0000;
    end
    // Bus released outside injection: inverse of the last value
    always @(posedge clk_i) begin
        if (cpu_state_i !== STAT_INJECT) begin
            instr_bus_o <= ~instr_bus_o;
        end
    end
    // Two-pin changes are refused; callers space changes apart
    task automatic set_mode(input logic [1:0] m);
        if ($countones(m ^ mode_ctrl_o) == 1) begin
            mode_ctrl_o <= m;
        end
    endtask : set_mode
    // Drives a plain word only once injection shows on the state pins
    task automatic put(input logic [INSTR_W-1:0] w);
        if (cpu_state_i === STAT_INJECT) begin
            instr_bus_o <= w;
        end
    endtask : put
endmodule : dit_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the debug injection controller
// Assumes: Host model owns mode pins and instruction bus
// Notes: Expected words come from a queue filled as the host drives
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bench
module tb_top;
    import dit_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic float_test_n_i = 1'b1;
    logic rdy_n = 1'b1;
    logic err_n = 1'b1;
    logic [31:0] fetch_instr = 32'h0000_0000;
    logic fetch_valid = 1'b0;
    logic pipe_hold = 1'b0;
    logic data_busy_i = 1'b0;
    logic compare_error_i = 1'b0;
    logic [1:0] mode;
    logic [31:0] bus, dhr, held;
    logic dhr_valid, adv, pre, refetch, resume, spr_inh, priv;
    logic [2:0] cpu_state;
    logic st_oe, out_oe, clk_oe, master_slave_compare_error;
    int fails = 0;
    int compares = 0;
    int seed = 5341;
    int cyc = 0;
    int n_adv = 0, n_pre = 0, n_ref = 0, n_res = 0;
    logic [1:0] cur = MODE_NORMAL;
    logic [31:0] exp_q[$];
    dit_inject_ctrl i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_ctrl_i(mode),
        .float_test_n_i(float_test_n_i), .instr_bus_i(bus), .instruction_ready_n_i(rdy_n),
        .instruction_error_n_i(err_n), .fetch_instr_i(fetch_instr), .fetch_valid_i(fetch_valid),
        .pipe_hold_i(pipe_hold), .data_busy_i(data_busy_i), .decode_holding_register_o(dhr),
        .dhr_valid_o(dhr_valid), .stage_advance_o(adv), .burst_preempt_o(pre),
        .refetch_o(refetch), .resume_return_o(resume), .spr_update_inhibit_o(spr_inh),
        .priv_override_o(priv), .cpu_state_o(cpu_state), .cpu_state_oe_o(st_oe),
        .outputs_oe_o(out_oe), .system_clock_pin_oe_o(clk_oe),
        .master_slave_compare_error_o(master_slave_compare_error), .compare_error_i(compare_error_i));
    dit_host_model i_host (.clk_i(clk_i), .cpu_state_i(cpu_state), .mode_ctrl_o(mode),
        .instr_bus_o(bus));
    // Clock is always supplied by the bench, so floating its pin is safe
    always #2 clk_i = ~clk_i;
    // Pulses stand one cycle; count them mid-cycle
    always @(negedge clk_i) begin
        n_adv += int'(adv === 1'b1);
        n_pre += int'(pre === 1'b1);
        n_ref += int'(refetch === 1'b1);
        n_res += int'(resume === 1'b1);
    end
    // Hang guard, far above the roughly 100 cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end
    // ==========================================================
    // Compare and model helpers
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t word %h exp %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_stat(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t state %b exp %b", $time, got, exp);
        end
    endtask : cmp_stat
    task automatic cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
        end
    endtask : cmp_flag
    function automatic logic [2:0] stat_of(input logic [1:0] m);
        if (m == MODE_INJECT) return STAT_INJECT;
        if (m == MODE_NORMAL) return STAT_RUN;
        return STAT_IDLE;
    endfunction : stat_of
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // Old code must stand two edges, new one must show by the fourth
    task automatic go(input logic [1:0] m);
        @(posedge clk_i);
        i_host.set_mode(m);
        tick(2);
        #1 cmp_stat(cpu_state, stat_of(cur));
        tick(2);
        #1 cmp_stat(cpu_state, stat_of(m));
        cur = m;
    endtask : go
    // Inject n+1 words while fetch, ready and error inputs churn
    task automatic inject(input int n);
        logic [31:0] w;
        logic [31:0] r;
        logic ce;
        go(MODE_INJECT);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_i);
            w = $random(seed);
            r = $random(seed);
            i_host.put(w);
            fetch_instr <= $random(seed);
            fetch_valid <= 1'b1;
            rdy_n <= r[0];
            err_n <= r[1];
            pipe_hold <= r[2];
            compare_error_i <= r[3];
            #1;
            if (i > 0) cmp_word(dhr, exp_q.pop_front());
            if (i > 0) cmp_flag(master_slave_compare_error, ce);
            exp_q.push_back(w);
            ce = r[3];
        end
        pipe_hold <= 1'b0;
        held = w;
        exp_q.delete();
    endtask : inject
    // One step; for busy above 0 pipeline hold first blocks the advance, then data busy blocks the end
    task automatic step(input int busy);
        int a0;
        a0 = n_adv;
        @(posedge clk_i);
        i_host.set_mode(MODE_NORMAL);
        data_busy_i <= 1'b1;
        pipe_hold <= (busy > 0);
        tick(4 + busy);
        #1 cmp_stat(cpu_state, STAT_RUN);
        if (busy > 0) cmp_word(32'(n_adv - a0), 32'h0000_0000);
        @(posedge clk_i);
        pipe_hold <= 1'b0;
        tick(2);
        #1 cmp_stat(cpu_state, STAT_RUN);
        cmp_word(32'(n_adv - a0), 32'h0000_0001);
        @(posedge clk_i);
        data_busy_i <= 1'b0;
        tick(4);
        #1 cmp_stat(cpu_state, STAT_IDLE);
        cmp_word(32'(n_adv - a0), 32'h0000_0001);
        cmp_word(dhr, held);
        cmp_flag(dhr_valid, 1'b1);
        go(MODE_STEP);
    endtask : step
    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // ==========================================================
    // Main sequence
    initial begin
        tick(6);
        sys_rst_i <= 1'b0;
        #1 cmp_stat(cpu_state, STAT_RUN);
        cmp_flag(dhr_valid, 1'b0);
        cmp_flag(out_oe, 1'b1);
        go(MODE_HALT);
        inject(8);
        cmp_word(32'(n_pre), 32'h0000_0001);
        go(MODE_STEP);
        tick(2);
        #1 cmp_word(dhr, held);
        cmp_flag(dhr_valid, 1'b1);
        cmp_flag(spr_inh, 1'b1);
        cmp_flag(priv, 1'b1);
        step(3);
        step(0);
        inject(4);
        go(MODE_HALT);
        tick(2);
        #1 cmp_flag(dhr_valid, 1'b0);
        cmp_flag(priv, 1'b0);
        cmp_word(32'(n_ref), 32'h0000_0001);
        @(posedge clk_i);
        float_test_n_i <= 1'b0;
        compare_error_i <= 1'b1;
        #1 cmp_flag(out_oe, 1'b0);
        cmp_flag(st_oe, 1'b0);
        cmp_flag(clk_oe, 1'b0);
        @(posedge clk_i);
        float_test_n_i <= 1'b1;
        #1 cmp_flag(master_slave_compare_error, 1'b1);
        cmp_flag(out_oe, 1'b1);
        fetch_instr <= 32'h5a5a_0f0f;
        go(MODE_NORMAL);
        tick(4);
        #1 cmp_word(32'(n_res), 32'h0000_0001);
        cmp_word(dhr, 32'h5a5a_0f0f);
        cmp_word(32'(n_pre), 32'h0000_0002);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
